// ### design/ebr_byte_lane_reorder.sv
/*
 byte lane reordering between memory, caches and general registers for
 per-region endian storage. one register stage on each path: the fill word
 toward the instruction cache, the word toward decode, the load result toward
 the general register and the store bytes toward the data cache.
 assumes all inputs come from logic on core_clk; the caches, the translation
 lookup and alignment exceptions live outside and only consume the flags here.
 assumes the data cache gathers the bytes of a misaligned access into address
 order, lowest address in the top lane, and scatters store bytes the same way.
*/
`timescale 1ns/1ps
`include "ebr_defs.svh"

// Operation
// - every fetch and load/store carries endian attribute, 0 big, 1 little
// - translation on: attribute comes from matching translation entry endian field
// - translation off: attribute comes from region endian select register
// - instruction relocate is bit 26, data relocate bit 27; 1 enables
// - little endian leaves address alone; only bytes are reordered in transfer
// - little endian instruction word has all four bytes reversed before icache
// - instruction cache holds big endian words; decode gets them unmodified
// - lowest address byte of instruction word is its most significant byte
// - data is not reversed into data cache; reorder between cache and registers
// - little endian byte access passes the byte unchanged
// - little endian halfword access swaps its two bytes
// - little endian word access reverses its four bytes
// - size-based reversal is identical for aligned and misaligned accesses
// - alignment flags ignore endian; little endian adds no alignment faults
// - default big endian puts most significant byte at lowest address
// - byte-reverse accesses map significant register bytes to higher addresses
// - byte-reverse little endian equals normal big endian, and conversely
// - no architected little endian mode; per-region attributes only
module ebr_byte_lane_reorder (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // endian controls
  input wire logic [31:0] machineStateReg,
  input wire logic [31:0] regionEndianSelectReg,
  // instruction fill from memory
  input wire logic fetchValid,
  input wire logic [31:0] fetchAddr,
  input wire logic fetchTlbEndian,
  input wire logic [31:0] fetchMemWord,
  // fill toward the instruction cache
  output logic icacheFillValid,
  output logic [31:0] icacheFillWord,
  output logic icacheFillEndian,
  // instruction cache to decode
  input wire logic icacheReadValid,
  input wire logic [31:0] icacheReadWord,
  output logic decodeValid,
  output logic [31:0] decodeWord,
  output logic [5:0] decodeOpcode,
  // load from the data cache
  input wire logic loadValid,
  input wire logic [31:0] loadAddr,
  input wire ebr_pkg::ebr_size_e loadSize,
  input wire logic loadByteRev,
  input wire logic loadSignExt,
  input wire logic loadTlbEndian,
  input wire logic [31:0] loadCacheBytes,
  // load result toward the general register
  output logic loadDone,
  output logic [31:0] loadResult,
  output logic loadEndian,
  output logic loadMisaligned,
  // store from the general register
  input wire logic storeValid,
  input wire logic [31:0] storeAddr,
  input wire ebr_pkg::ebr_size_e storeSize,
  input wire logic storeByteRev,
  input wire logic storeTlbEndian,
  input wire logic [31:0] storeRegData,
  // store bytes toward the data cache
  output logic storeDone,
  output logic [31:0] storeCacheBytes,
  output logic [3:0] storeByteMask,
  output logic storeEndian,
  output logic storeMisaligned
);

  // control bits counted from the most significant end
  localparam int IrPos = 31 - `EBR_MSR_IR_BIT;
  localparam int DrPos = 31 - `EBR_MSR_DR_BIT;

  ebr_pkg::ebr_state_s state;
  ebr_pkg::ebr_state_s next_state;

  // relocate controls picked out of the machine state word
  logic instrRelocate;
  logic dataRelocate;

  // endian attribute per path, 1 means little
  logic fetchEndian;
  logic loadRegionEndian;
  logic storeRegionEndian;

  // final lane reversal per data path
  logic loadReverse;
  logic storeReverse;

  // fill word with its four lanes reversed
  logic [31:0] fillReversed;

  // region endian select bit 0 is region 0 at the top of the register;
  // the region index is the top five address bits, so 32 regions in all
  function automatic logic regionEndian(
    input logic relocate,
    input logic tlbEndian,
    input logic [31:0] sel,
    input logic [31:0] addr
  );
    logic [4:0] region;
    region = addr[`EBR_REGION_MSB:`EBR_REGION_LSB];
    if (relocate) begin
      regionEndian = tlbEndian;
    end else begin
      regionEndian = sel[~region];
    end
  endfunction : regionEndian

  function automatic logic [31:0] swapWord(input logic [31:0] w);
    swapWord = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : swapWord

  // one loop over the four lanes: memory lane k lands in lane 3-k
  for (genvar lane = 0; lane < 4; lane++) begin : g_fill_lane
    assign fillReversed[8*lane +: 8] = fetchMemWord[8*(3-lane) +: 8];
  end

  // cache bytes arrive in address order from the access address, top lane first,
  // so misaligned accesses reorder exactly like aligned ones
  // an illegal size code gives zero rather than stale bytes
  function automatic logic [31:0] loadAlign(
    input logic [31:0] b,
    input ebr_pkg::ebr_size_e sz,
    input logic rev,
    input logic sext
  );
    logic [31:0] r;
    r = `EBR_RESET_WORD;
    unique case (sz)
      ebr_pkg::EBR_BYTE: begin
        r = {{24{sext & b[31]}}, b[31:24]};
      end
      ebr_pkg::EBR_HALF: begin
        if (rev) begin
          r = {{16{sext & b[23]}}, b[23:16], b[31:24]};
        end else begin
          r = {{16{sext & b[31]}}, b[31:24], b[23:16]};
        end
      end
      ebr_pkg::EBR_WORD: begin
        if (rev) begin
          r = swapWord(b);
        end else begin
          r = b;
        end
      end
      default: begin
        r = `EBR_RESET_WORD;
      end
    endcase
    loadAlign = r;
  endfunction : loadAlign

  // unused lanes stay zero; the byte mask names the live ones
  function automatic logic [31:0] storeAlign(
    input logic [31:0] v,
    input ebr_pkg::ebr_size_e sz,
    input logic rev
  );
    logic [31:0] r;
    r = `EBR_RESET_WORD;
    unique case (sz)
      ebr_pkg::EBR_BYTE: begin
        r = {v[7:0], 24'h000000};
      end
      ebr_pkg::EBR_HALF: begin
        if (rev) begin
          r = {v[7:0], v[15:8], 16'h0000};
        end else begin
          r = {v[15:8], v[7:0], 16'h0000};
        end
      end
      ebr_pkg::EBR_WORD: begin
        if (rev) begin
          r = swapWord(v);
        end else begin
          r = v;
        end
      end
      default: begin
        r = `EBR_RESET_WORD;
      end
    endcase
    storeAlign = r;
  endfunction : storeAlign

  // lanes in address order, top lane first, like the store bytes
  function automatic logic [3:0] sizeMask(input ebr_pkg::ebr_size_e sz);
    unique case (sz)
      ebr_pkg::EBR_BYTE: begin
        sizeMask = `EBR_MASK_BYTE;
      end
      ebr_pkg::EBR_HALF: begin
        sizeMask = `EBR_MASK_HALF;
      end
      ebr_pkg::EBR_WORD: begin
        sizeMask = `EBR_MASK_WORD;
      end
      default: begin
        sizeMask = `EBR_MASK_NONE;
      end
    endcase
  endfunction : sizeMask

  // natural alignment only; the endian attribute never enters here
  function automatic logic misaligned(input ebr_pkg::ebr_size_e sz, input logic [1:0] a);
    unique case (sz)
      ebr_pkg::EBR_BYTE: begin
        misaligned = 1'b0;
      end
      ebr_pkg::EBR_HALF: begin
        misaligned = a[0];
      end
      ebr_pkg::EBR_WORD: begin
        misaligned = (a != 2'h0);
      end
      default: begin
        misaligned = 1'b0;
      end
    endcase
  endfunction : misaligned

  always_comb begin
    instrRelocate = machineStateReg[IrPos];
    dataRelocate = machineStateReg[DrPos];

    // fetch picks the instruction relocate bit; load and store share the data relocate bit
    fetchEndian = regionEndian(instrRelocate, fetchTlbEndian, regionEndianSelectReg,
                               fetchAddr);
    loadRegionEndian = regionEndian(dataRelocate, loadTlbEndian, regionEndianSelectReg,
                                    loadAddr);
    storeRegionEndian = regionEndian(dataRelocate, storeTlbEndian, regionEndianSelectReg,
                                     storeAddr);

    // the two reversals cancel, so byte-reverse just flips the attribute
    loadReverse = (loadRegionEndian == `EBR_ENDIAN_LITTLE) ^ loadByteRev;
    storeReverse = (storeRegionEndian == `EBR_ENDIAN_LITTLE) ^ storeByteRev;
  end

  always_comb begin
    next_state = state;
    // fill path: addresses pass untouched, only lanes move
    next_state.fillValid = fetchValid;
    if (fetchValid) begin
      next_state.fillEndian = fetchEndian;
      if (fetchEndian == `EBR_ENDIAN_LITTLE) begin
        next_state.fillWord = fillReversed;
      end else begin
        next_state.fillWord = fetchMemWord;
      end
    end

    // decode path: cache already big endian, no endian control here at all
    next_state.decodeValid = icacheReadValid;
    if (icacheReadValid) begin
      next_state.decodeWord = icacheReadWord;
      next_state.decodeOpcode = icacheReadWord[`EBR_OPCODE_MSB:`EBR_OPCODE_LSB];
    end

    // load path: cache holds memory image, reorder on the way to the register
    next_state.loadDone = loadValid;
    if (loadValid) begin
      next_state.loadEndian = loadRegionEndian;
      next_state.loadResult = loadAlign(loadCacheBytes, loadSize, loadReverse,
                                        loadSignExt);
      next_state.loadMisaligned = misaligned(loadSize, loadAddr[1:0]);
    end

    // store path: reorder before the cache, never after
    next_state.storeDone = storeValid;
    if (storeValid) begin
      next_state.storeEndian = storeRegionEndian;
      next_state.storeData = storeAlign(storeRegData, storeSize, storeReverse);
      next_state.storeMask = sizeMask(storeSize);
      next_state.storeMisaligned = misaligned(storeSize, storeAddr[1:0]);
    end
  end

  // no mode input exists: reordering is driven by the endian attributes and the byte-reverse flags
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // fill path
      state.fillValid <= 1'b0;
      state.fillWord <= `EBR_RESET_WORD;
      state.fillEndian <= `EBR_ENDIAN_BIG;

      // decode path
      state.decodeValid <= 1'b0;
      state.decodeWord <= `EBR_RESET_WORD;
      state.decodeOpcode <= `EBR_RESET_OPCODE;

      // load path
      state.loadDone <= 1'b0;
      state.loadResult <= `EBR_RESET_WORD;
      state.loadEndian <= `EBR_ENDIAN_BIG;
      state.loadMisaligned <= 1'b0;

      // store path
      state.storeDone <= 1'b0;
      state.storeData <= `EBR_RESET_WORD;
      state.storeMask <= `EBR_MASK_NONE;
      state.storeEndian <= `EBR_ENDIAN_BIG;
      state.storeMisaligned <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // stale icache lines after an endian change are software's to flush
  // fill outputs
  assign icacheFillValid = state.fillValid;
  assign icacheFillWord = state.fillWord;
  assign icacheFillEndian = state.fillEndian;

  // decode outputs
  assign decodeValid = state.decodeValid;
  assign decodeWord = state.decodeWord;
  assign decodeOpcode = state.decodeOpcode;

  // load outputs
  assign loadDone = state.loadDone;
  assign loadResult = state.loadResult;
  assign loadEndian = state.loadEndian;
  assign loadMisaligned = state.loadMisaligned;

  // store outputs
  assign storeDone = state.storeDone;
  assign storeCacheBytes = state.storeData;
  assign storeByteMask = state.storeMask;
  assign storeEndian = state.storeEndian;
  assign storeMisaligned = state.storeMisaligned;

endmodule : ebr_byte_lane_reorder

// ### design/ebr_defs.svh
/*
 constants for the endian byte lane reorder block: control bit positions,
 field positions and reset values. assumes 32-bit words, byte 0 = lowest address.
*/
`ifndef EBR_DEFS_SVH
`define EBR_DEFS_SVH

// machine state control bits, numbered with bit 0 as the most significant
`define EBR_MSR_IR_BIT 26
`define EBR_MSR_DR_BIT 27
// endian attribute values
`define EBR_ENDIAN_BIG 1'b0
`define EBR_ENDIAN_LITTLE 1'b1
// region index field of an address, one region endian select bit per region
`define EBR_REGION_MSB 31
`define EBR_REGION_LSB 27
// primary opcode field of an instruction word
`define EBR_OPCODE_MSB 31
`define EBR_OPCODE_LSB 26
// byte lane masks in address order, lowest address in the top lane
`define EBR_MASK_BYTE 4'h8
`define EBR_MASK_HALF 4'hC
`define EBR_MASK_WORD 4'hF
`define EBR_MASK_NONE 4'h0
// reset values
`define EBR_RESET_WORD 32'h00000000
`define EBR_RESET_OPCODE 6'h00

`endif

// ### design/ebr_pkg.sv
/*
 types for the endian byte lane reorder block.
 assumes the defs header is included by each user.
*/
package ebr_pkg;

  typedef enum logic [1:0] {
    EBR_BYTE,
    EBR_HALF,
    EBR_WORD
  } ebr_size_e;

  typedef struct packed {
    logic fillValid;
    logic [31:0] fillWord;
    logic fillEndian;
    logic decodeValid;
    logic [31:0] decodeWord;
    logic [5:0] decodeOpcode;
    logic loadDone;
    logic [31:0] loadResult;
    logic loadEndian;
    logic loadMisaligned;
    logic storeDone;
    logic [31:0] storeData;
    logic [3:0] storeMask;
    logic storeEndian;
    logic storeMisaligned;
  } ebr_state_s;

endpackage : ebr_pkg

// ### tb/ebr_chk.sv
/* checker: port assertions for the byte lane reorder block.
 assumes one core_clk domain with async active-low rstn. */
`timescale 1ns/1ps
module ebr_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // controls
  input wire logic [31:0] machineStateReg,
  input wire logic [31:0] regionEndianSelectReg,
  // fetch and decode
  input wire logic fetchValid,
  input wire logic fetchTlbEndian,
  input wire logic icacheFillValid,
  input wire logic icacheFillEndian,
  input wire logic [31:0] fetchAddr,
  input wire logic [31:0] fetchMemWord,
  input wire logic [31:0] icacheFillWord,
  input wire logic icacheReadValid,
  input wire logic decodeValid,
  input wire logic [31:0] icacheReadWord,
  input wire logic [31:0] decodeWord,
  // load and store
  input wire logic loadValid,
  input wire logic loadByteRev,
  input wire logic loadTlbEndian,
  input wire logic loadDone,
  input wire logic loadEndian,
  input wire logic loadMisaligned,
  input wire logic [31:0] loadAddr,
  input wire logic [31:0] loadCacheBytes,
  input wire logic [31:0] loadResult,
  input wire ebr_pkg::ebr_size_e loadSize,
  input wire ebr_pkg::ebr_size_e storeSize,
  input wire logic storeValid,
  input wire logic [3:0] storeByteMask
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic fEnd, lEnd, lRev;
  // region bit index 31-r is the inverse of r
  assign fEnd = machineStateReg[5] ? fetchTlbEndian : regionEndianSelectReg[~fetchAddr[31:27]];
  assign lEnd = machineStateReg[4] ? loadTlbEndian : regionEndianSelectReg[~loadAddr[31:27]];
  assign lRev = lEnd ^ loadByteRev;
  function automatic logic [31:0] sw4(logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : sw4
  chk_fill_order: assert property (
    fetchValid |=> icacheFillValid && icacheFillWord ==
      ($past(fEnd) ? sw4($past(fetchMemWord)) : $past(fetchMemWord))) else $error("fill");
  chk_fill_attr: assert property (
    fetchValid |=> icacheFillEndian == $past(fEnd)) else $error("fill attr");
  chk_decode_pass: assert property (
    icacheReadValid |=> decodeValid && decodeWord == $past(icacheReadWord)) else $error("dec");
  chk_load_attr: assert property (
    loadValid |=> loadDone && loadEndian == $past(lEnd)) else $error("load attr");
  chk_load_word: assert property (
    loadValid && loadSize == ebr_pkg::EBR_WORD |=> loadResult ==
      ($past(lRev) ? sw4($past(loadCacheBytes)) : $past(loadCacheBytes))) else $error("word");
  chk_half_align: assert property (
    loadValid && loadSize == ebr_pkg::EBR_HALF |=> loadMisaligned == $past(loadAddr[0]))
    else $error("align");
  chk_load_quiet: assert property (
    !loadValid |=> !loadDone) else $error("done");
  chk_half_mask: assert property (
    storeValid && storeSize == ebr_pkg::EBR_HALF |=> storeByteMask == 4'hC) else $error("mask");
  cover property (fetchValid && fEnd);
  cover property (loadValid && lRev && loadSize == ebr_pkg::EBR_WORD);
  cover property (storeValid && storeSize == ebr_pkg::EBR_HALF);
endmodule : ebr_chk
bind ebr_byte_lane_reorder ebr_chk ebr_chk_i (.*);

// ### tb/ebr_mem_model.sv
/* memory side model: serves stored bytes for fetches and loads.
 assumes bytes leave in address order, lowest address in the top lane. */
`timescale 1ns/1ps
module ebr_mem_model (
  // request addresses
  input wire logic [31:0] fetchAddr,
  input wire logic [31:0] loadAddr,
  // stored bytes
  output logic [31:0] fetchMemWord,
  output logic [31:0] loadCacheBytes
);
  // image handed over as stored; any reorder is the block's job
  // words follow the address alone, so no stale image outlives an endian change
  assign fetchMemWord = {fetchAddr[15:0], fetchAddr[31:16]} ^ 32'hA5C33CA5;
  assign loadCacheBytes = {loadAddr[7:0], loadAddr[31:8]} ^ 32'h5A3CC35A;
endmodule : ebr_mem_model

// ### tb/tb.sv
/* testbench: random traffic on all four paths against a queue model.
 assumes the memory model serves fetch and load bytes. */
`timescale 1ns/1ps
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, x); end end
module tb;
  logic core_clk, rstn, fetchValid, fetchTlbEndian, icacheFillValid, icacheFillEndian;
  logic icacheReadValid, decodeValid, loadValid, loadByteRev, loadSignExt, loadTlbEndian;
  logic loadDone, loadEndian, loadMisaligned, storeValid, storeByteRev, storeTlbEndian;
  logic storeDone, storeEndian, storeMisaligned, pf, pi, pl, ps;
  logic [31:0] machineStateReg, regionEndianSelectReg, fetchAddr, fetchMemWord, icacheFillWord;
  logic [31:0] icacheReadWord, decodeWord, loadAddr, loadCacheBytes, loadResult, storeAddr;
  logic [31:0] storeRegData, storeCacheBytes;
  logic [5:0] decodeOpcode;
  logic [3:0] storeByteMask;
  logic [32:0] eF;
  logic [37:0] eD, eS;
  logic [33:0] lq[$];
  logic [3:0] mk[4] = '{4'h8, 4'hC, 4'hF, 4'h0};
  ebr_pkg::ebr_size_e loadSize, storeSize;
  int n_mismatch = 0, n_checks = 0, seed = 32'h331784a8;
  ebr_byte_lane_reorder ebr_byte_lane_reorder_i (.*);
  ebr_mem_model ebr_mem_model_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // tests take about 800 cycles; several times that before giving up
  initial begin
    #20000 n_mismatch++;
    end_sim();
  end
  function automatic logic [31:0] sw(logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : sw
  function automatic logic at(logic rl, logic tlb, logic [31:0] a);
    return rl ? tlb : regionEndianSelectReg[31 - a[31:27]];
  endfunction : at
  function automatic logic mis(logic [31:0] a, int sz);
    return (sz == 1 && a[0]) || (sz == 2 && a[1:0] != 2'h0);
  endfunction : mis
  function automatic logic [31:0] ld(logic [31:0] b, int sz, logic rv, logic sx);
    logic [15:0] h;
    h = rv ? {b[23:16], b[31:24]} : b[31:16];
    case (sz)
      0: return sx ? {{24{b[31]}}, b[31:24]} : {24'h0, b[31:24]};
      1: return sx ? {{16{h[15]}}, h} : {16'h0, h};
      2: return rv ? sw(b) : b;
      default: return 32'h0;
    endcase
  endfunction : ld
  function automatic logic [31:0] st(logic [31:0] v, int sz, logic rv);
    case (sz)
      0: return {v[7:0], 24'h0};
      1: return rv ? {v[7:0], v[15:8], 16'h0} : {v[15:0], 16'h0};
      2: return rv ? sw(v) : v;
      default: return 32'h0;
    endcase
  endfunction : st
  // lit: all regions little, translation off, every path busy each cycle
  task automatic drive(logic lit);
    logic fe, le, se;
    {fetchValid, icacheReadValid, loadValid, storeValid} = lit ? 4'hF : 4'($random(seed));
    {fetchTlbEndian, loadTlbEndian, storeTlbEndian} = 3'($random(seed));
    {loadByteRev, storeByteRev, loadSignExt} = 3'($random(seed));
    machineStateReg = lit ? 32'h0 : $random(seed);
    regionEndianSelectReg = lit ? 32'hFFFFFFFF : $random(seed);
    fetchAddr = $random(seed) & 32'hFFFFFFFC;
    loadAddr = $random(seed);
    storeAddr = $random(seed);
    icacheReadWord = $random(seed);
    storeRegData = $random(seed);
    loadSize = ebr_pkg::ebr_size_e'(2'($random(seed)));
    storeSize = ebr_pkg::ebr_size_e'(2'($random(seed)));
    #1;
    {pf, pi, pl, ps} = {fetchValid, icacheReadValid, loadValid, storeValid};
    fe = at(machineStateReg[5], fetchTlbEndian, fetchAddr);
    le = at(machineStateReg[4], loadTlbEndian, loadAddr);
    se = at(machineStateReg[4], storeTlbEndian, storeAddr);
    eF = {fe, fe ? sw(fetchMemWord) : fetchMemWord};
    eD = {icacheReadWord, icacheReadWord[31:26]};
    eS = {se, mis(storeAddr, storeSize), mk[storeSize],
      st(storeRegData, storeSize, se ^ storeByteRev)};
    if (loadValid)
      lq.push_back({le, mis(loadAddr, loadSize),
        ld(loadCacheBytes, loadSize, le ^ loadByteRev, loadSignExt)});
  endtask : drive
  task automatic check_outs();
    logic [33:0] e;
    `CHK({icacheFillValid, decodeValid, loadDone, storeDone}, {pf, pi, pl, ps})
    if (pf)
      `CHK({icacheFillEndian, icacheFillWord}, eF)
    if (pi)
      `CHK({decodeWord, decodeOpcode}, eD)
    if (pl) begin
      e = lq.pop_front();
      `CHK(loadResult, e[31:0])
      `CHK({loadEndian, loadMisaligned}, e[33:32])
    end
    if (ps) begin
      `CHK(storeCacheBytes, eS[31:0])
      `CHK({storeEndian, storeMisaligned, storeByteMask}, eS[37:32])
    end
  endtask : check_outs
  task automatic run(int n, logic lit);
    repeat (n) begin
      @(negedge core_clk);
      check_outs();
      drive(lit);
    end
    $display("test lit=%0d ended, checks %0d", lit, n_checks);
  endtask : run
  task automatic do_reset();
    @(negedge core_clk);
    rstn = 1'b0;
    {fetchValid, icacheReadValid, loadValid, storeValid, pf, pi, pl, ps} = 8'h0;
    lq.delete();
    repeat (1) @(negedge core_clk);
    `CHK({icacheFillValid, decodeValid, loadDone, storeDone, loadResult}, 36'h0)
    rstn = 1'b1;
  endtask : do_reset
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    rstn = 1'b0;
    drive(1'b0);
    do_reset();
    run(400, 1'b0);
    do_reset();
    run(200, 1'b1);
    run(200, 1'b0);
    end_sim();
  end
endmodule : tb
